// ===== ccg_params.svh
// constants for the clock pulse generator: offsets, field positions, resets, counts
// assumes inclusion by bare name from the filter and top modules
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH

// register byte offsets (one aligned word each)
`define CCG_OFS_STANDBY 4'h0
`define CCG_OFS_LOWPWR 4'h4
`define CCG_OFS_MODSTOP 4'h8
`define CCG_OFS_STATUS 4'hc

// standby control field positions
`define CCG_SBY_SOFTWARE_STANDBY_BIT_BIT 7
`define CCG_SBY_STS_LSB 4
`define CCG_SBY_FAST_BIT 3
`define CCG_SBY_SCK_LSB 0

// low power control field positions
`define CCG_LPW_NOISE_FILTER_SAMPLING_SELECT_BIT 5
`define CCG_LPW_SUBCLOCK_INPUT_ENABLE_BIT 4

// reset values
`define CCG_SBY_RESET 8'h00
`define CCG_LPW_RESET 8'h00
`define CCG_MSTOP_RESET 16'h0000

// multiplier stage ratio and divider layout
`define CCG_PLL_MULT 3'h4
`define CCG_DIV_W 5
`define CCG_SEL_MAX 3'h5
`define CCG_NOISE_FILTER_SAMPLING_SELECT_SLOW 3'h5
`define CCG_NOISE_FILTER_SAMPLING_SELECT_FAST 3'h2

// settling wait for select code 000, in system clock states
`define CCG_SETTLE_BASE 8192
// equal samples needed before the filtered subclock changes level
`define CCG_FILT_SAMPLES 3

`endif

// ===== ccg_pkg.sv
// types shared by the clock pulse generator modules
// assumes ccg_params.svh on the include path
package ccg_pkg;

  // power mode of the device
  typedef enum logic [2:0] {
    CCG_RUN,
    CCG_SLEEP,
    CCG_SWSTBY,
    CCG_SETTLE,
    CCG_HWSTBY
  } ccg_mode_t;

  // standby control layout, msb first
  typedef struct packed {
    logic sw_standby;
    logic [2:0] timer_sel;
    logic xfer_fast;
    logic [2:0] clk_sel;
  } ccg_sby_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic cpu_en;
    logic dtc_en;
    logic periph_en;
  } ccg_en_t;

endpackage

// ===== ccg_subclk_filter.sv
// noise filter for the external subclock pin
// assumes pin is asynchronous to hclk; sample_en is a one-cycle pulse on hclk
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"

module ccg_subclk_filter import ccg_pkg::*; #(
  parameter int SAMPLES = `CCG_FILT_SAMPLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic enable,
  input wire logic sample_en,
  // pin and filtered level
  input wire logic pin,
  output logic level
);

  if (SAMPLES < 2) begin : g_chk
    $error("ccg_subclk_filter: SAMPLES must be at least 2");
  end

  logic sync1_reg;
  logic sync2_reg;
  logic [SAMPLES-1:0] hist_reg;
  logic [SAMPLES-1:0] hist_next;
  logic level_reg;
  logic level_next;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // level follows only after a full run of equal samples, so short spikes die here
  always_comb begin
    hist_next = hist_reg;
    level_next = level_reg;
    if (!enable) begin
      hist_next = '0;
      level_next = 1'b0;
    end else if (sample_en) begin
      hist_next = {hist_reg[SAMPLES-2:0], sync2_reg};
      if (&hist_next) begin
        level_next = 1'b1;
      end else if (~|hist_next) begin
        level_next = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule
`default_nettype wire

// ===== ccg_subclk_src.sv
// external subclock source model driving the subclock pin
// assumes hclk as its time base; half period given in hclk cycles
`timescale 1ns/1ps
`default_nettype none
module ccg_subclk_src #(
  parameter int HALF = 128
) (
  // time base
  input wire logic hclk,
  // control
  input wire logic run,
  input wire logic glitch,
  // pin
  output logic pin
);
  int cnt = 0;
  logic sq = 1'b0;
  // square wave while run; the glitch input flips the pin as noise would
  always @(posedge hclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (run && cnt == HALF - 1) begin
      sq <= !sq;
    end
  end
  assign pin = sq ^ glitch;
endmodule
`default_nettype wire

// ===== ccg_top.sv
// clock pulse generator and power-down control, one system clock domain
// assumes hclk is the multiplied system clock; slower clocks leave as enables
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"

// Contract
// R01: system clock is oscillator times four
// R02: divider gives half down to thirty-second
// R03: bus master clock chosen by select field
// R04: select resets to 000; 11X forbidden
// R05: new speed applies after bus cycle ends
// R06: fast bit puts transfer controller on system
// R07: transfer request switches it to system clock
// R08: source supplies 32.768 kHz; software enables input
// R09: subclock sampled by divided clock filter
// R10: sampling select 0 gives /32, 1 gives /4
// R11: multiplied oscillator selected on every return
// R12: system holds reset during external settle delay
// R13: sleep instruction enters sleep or software standby
// R14: interrupts never change software standby bit
// R15: settle wait after standby chosen by field
// R16: codes give 8192 to 262144 states; 11X reserved
// R17: software picks wait of 8 ms or 500 us
// R18: flash enable clear before power register access
// R19: sleep halts processor, peripherals keep running
// R20: software standby stops oscillator and everything
// R21: hardware standby stops oscillator, resets everything; code raises periph_reset only, its own registers keep their values
// R22: each peripheral can be stopped individually
// R23: speed switch is glitch-free
module ccg_top import ccg_pkg::*; #(
  parameter int SETTLE_BASE = `CCG_SETTLE_BASE,
  parameter int MSTOP_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // processor and transfer controller events
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic bus_cycle_done,
  input wire logic dtc_req,
  input wire logic flash_enable_bit,
  // pins
  input wire logic hw_standby_n,
  input wire logic subclock_pin,
  // clock enables and power state
  output ccg_en_t clk_en,
  output logic cpu_halt,
  output logic periph_halt,
  output logic periph_reset,
  output logic osc_stop,
  output logic pll_select,
  output logic [MSTOP_W-1:0] module_stop,
  output logic subclock_out
);

  localparam int CW = $clog2(SETTLE_BASE) + 7;

  if (SETTLE_BASE < 1 || MSTOP_W < 1 || MSTOP_W > 32) begin : g_chk
    $error("ccg_top: SETTLE_BASE or MSTOP_W out of range");
  end

  // enable for system clock divided by 2**sel; sel 0 is every cycle
  function automatic logic div_tick(input logic [`CCG_DIV_W-1:0] cnt, input logic [2:0] sel);
    logic [`CCG_DIV_W-1:0] m;
    m = `CCG_DIV_W'((6'h01 << sel) - 6'h01);
    return (cnt & m) == m;
  endfunction

  // codes 11X are illegal in both three-bit fields
  function automatic logic code_ok(input logic [2:0] code);
    return code <= `CCG_SEL_MAX;
  endfunction

  // bus address phase capture
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [3:0] wr_addr_reg;
  logic [3:0] wr_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic addr_ok;

  // registers
  ccg_sby_t sby_reg;
  ccg_sby_t sby_next;
  logic [7:0] lpw_reg;
  logic [7:0] lpw_next;
  logic [MSTOP_W-1:0] mstop_reg;
  logic [MSTOP_W-1:0] mstop_next;

  // clocking state
  logic [`CCG_DIV_W-1:0] div_reg;
  logic [`CCG_DIV_W-1:0] div_next;
  logic [2:0] act_sel_reg;
  logic [2:0] act_sel_next;
  ccg_mode_t mode_reg;
  ccg_mode_t mode_next;
  logic [CW-1:0] settle_reg;
  logic [CW-1:0] settle_next;
  logic pll_reg;
  logic pll_next;
  logic hws1_reg;
  logic hws2_reg;
  logic filt_sample;
  logic filt_level;
  logic master_tick;
  logic write_ok;
  ccg_sby_t wr_sby;

  // address phase: transfers of any size to the low 16 bytes are decoded
  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:4] == 28'h0000000);

  always_comb begin
    wr_pend_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    if (addr_ok && hwrite) begin
      wr_pend_next = 1'b1;
      wr_addr_next = haddr[3:0];
    end
  end

  // register updates in the data phase, locked while flash enable is set
  assign write_ok = wr_pend_reg && !flash_enable_bit; // see R18
  assign wr_sby = ccg_sby_t'(hwdata[7:0]);

  always_comb begin
    sby_next = sby_reg;
    lpw_next = lpw_reg;
    mstop_next = mstop_reg;
    if (write_ok) begin
      unique case (wr_addr_reg)
        `CCG_OFS_STANDBY: begin
          // sleep bit changes only here, never on a wake transition
          sby_next.sw_standby = wr_sby.sw_standby; // see R14
          sby_next.xfer_fast = wr_sby.xfer_fast;
          if (code_ok(wr_sby.timer_sel)) begin
            sby_next.timer_sel = wr_sby.timer_sel; // see R16
          end
          if (code_ok(wr_sby.clk_sel)) begin
            sby_next.clk_sel = wr_sby.clk_sel; // see R04
          end
        end
        `CCG_OFS_LOWPWR: begin
          lpw_next = hwdata[7:0];
        end
        `CCG_OFS_MODSTOP: begin
          mstop_next = hwdata[MSTOP_W-1:0]; // see R22
        end
        default: begin
        end
      endcase
    end
  end

  // read data is taken from next values so a read right after a write sees it
  always_comb begin
    hrdata_next = hrdata_reg;
    if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata_next = 32'h00000000;
      unique case (addr_ok ? haddr[3:0] : 4'h1) // unmapped reads fall to default, zero
        `CCG_OFS_STANDBY: hrdata_next[7:0] = sby_next;
        `CCG_OFS_LOWPWR: hrdata_next[7:0] = lpw_next;
        `CCG_OFS_MODSTOP: hrdata_next[MSTOP_W-1:0] = mstop_next;
        `CCG_OFS_STATUS: begin
          hrdata_next[2:0] = act_sel_reg;
          hrdata_next[5:3] = mode_reg;
          hrdata_next[6] = pll_reg;
          hrdata_next[7] = filt_level;
          hrdata_next[10:8] = `CCG_PLL_MULT; // see R01
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 4'h0;
      hrdata_reg <= 32'h00000000;
      sby_reg <= ccg_sby_t'(`CCG_SBY_RESET); // see R04
      lpw_reg <= `CCG_LPW_RESET;
      mstop_reg <= MSTOP_W'(`CCG_MSTOP_RESET);
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      sby_reg <= sby_next;
      lpw_reg <= lpw_next;
      mstop_reg <= mstop_next;
    end
  end

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // hardware standby pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hws1_reg <= 1'b1;
      hws2_reg <= 1'b1;
    end else begin
      hws1_reg <= hw_standby_n;
      hws2_reg <= hws1_reg;
    end
  end

  // divider freezes while the oscillator is stopped
  always_comb begin
    div_next = osc_stop ? div_reg : div_reg + `CCG_DIV_W'(1); // see R02
    act_sel_next = act_sel_reg;
    // all ratios end their period together at the all-ones count, so the
    // switch there never cuts a period short; it waits for the bus cycle too
    if (bus_cycle_done && (&div_reg) && !osc_stop) begin
      act_sel_next = sby_reg.clk_sel; // see R05 see R23 see R03
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
      act_sel_reg <= 3'h0;
    end else begin
      div_reg <= div_next;
      act_sel_reg <= act_sel_next;
    end
  end

  // power mode sequencing
  always_comb begin
    mode_next = mode_reg;
    settle_next = settle_reg;
    pll_next = pll_reg;
    if (!hws2_reg) begin
      mode_next = CCG_HWSTBY;
    end else begin
      unique case (mode_reg)
        CCG_RUN: begin
          if (sleep_exec) begin
            mode_next = sby_reg.sw_standby ? CCG_SWSTBY : CCG_SLEEP; // see R13
          end
        end
        CCG_SLEEP: begin
          if (wake_irq) begin
            mode_next = CCG_RUN;
            pll_next = 1'b1; // see R11
          end
        end
        CCG_SWSTBY: begin
          if (wake_irq) begin
            mode_next = CCG_SETTLE;
            settle_next = CW'(SETTLE_BASE) << sby_reg.timer_sel; // see R15 see R16
          end
        end
        CCG_SETTLE: begin
          settle_next = settle_reg - CW'(1);
          if (settle_reg <= CW'(1)) begin
            mode_next = CCG_RUN;
            pll_next = 1'b1; // see R11
          end
        end
        CCG_HWSTBY: begin
          mode_next = CCG_SETTLE;
          settle_next = CW'(SETTLE_BASE);
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= CCG_RUN;
      settle_reg <= '0;
      pll_reg <= 1'b1; // see R11
    end else begin
      mode_reg <= mode_next;
      settle_reg <= settle_next;
      pll_reg <= pll_next;
    end
  end

  // mode to halt, stop and reset outputs
  assign cpu_halt = (mode_reg != CCG_RUN); // see R19
  assign periph_halt = (mode_reg == CCG_SWSTBY) || (mode_reg == CCG_SETTLE) ||
                       (mode_reg == CCG_HWSTBY); // see R20
  assign periph_reset = (mode_reg == CCG_HWSTBY); // see R21
  assign osc_stop = (mode_reg == CCG_SWSTBY) || (mode_reg == CCG_HWSTBY); // see R20 see R21
  assign pll_select = pll_reg;
  assign module_stop = mstop_reg; // see R22

  // bus master enables: processor on the chosen ratio, controller may run fast
  assign master_tick = div_tick(div_reg, act_sel_reg); // see R03
  assign clk_en.cpu_en = master_tick && !cpu_halt;
  assign clk_en.dtc_en = !periph_halt &&
                         (master_tick || (sby_reg.xfer_fast && dtc_req)); // see R06 see R07
  assign clk_en.periph_en = !periph_halt;

  // subclock sampling rate from the sampling select bit
  assign filt_sample = !osc_stop && div_tick(div_reg,
                       lpw_reg[`CCG_LPW_NOISE_FILTER_SAMPLING_SELECT_BIT] ? `CCG_NOISE_FILTER_SAMPLING_SELECT_FAST : `CCG_NOISE_FILTER_SAMPLING_SELECT_SLOW); // see R10

  ccg_subclk_filter #(
    .SAMPLES(`CCG_FILT_SAMPLES)
  ) u_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(lpw_reg[`CCG_LPW_SUBCLOCK_INPUT_ENABLE_BIT]), // see R08
    .sample_en(filt_sample), // see R09
    .pin(subclock_pin),
    .level(filt_level)
  );

  assign subclock_out = filt_level;

endmodule
`default_nettype wire

// ===== ccg_top_checker.sv
// port-level assertions for the clock pulse generator
// assumes one hclk domain and a bind onto every ccg_top instance
`timescale 1ns/1ps
`default_nettype none
module ccg_top_checker import ccg_pkg::*; #(
  parameter int MSTOP_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // events
  input wire logic sleep_exec,
  input wire logic wake_irq,
  // watched outputs
  input wire ccg_en_t clk_en,
  input wire logic cpu_halt,
  input wire logic periph_halt,
  input wire logic periph_reset,
  input wire logic osc_stop,
  input wire logic pll_select,
  input wire logic [MSTOP_W-1:0] module_stop
);
  logic stop_wr_reg;
  logic stop_wr_next;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // module stop write in its data phase; the register may only move then
  always_comb begin
    stop_wr_next = hsel && hready && htrans[1] && hwrite && (haddr == 32'h8);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_wr_reg <= 1'b0;
    end else begin
      stop_wr_reg <= stop_wr_next;
    end
  end
  a_pll_held: assert property (pll_select)
    else $error("multiplied clock not selected");
  a_hw_standby: assert property (periph_reset |-> osc_stop && periph_halt && cpu_halt)
    else $error("hardware standby state incomplete");
  a_stby_gated: assert property (osc_stop |-> periph_halt && cpu_halt && clk_en == 3'h0)
    else $error("clocks running with oscillator stopped");
  a_sleep_entry: assert property (!cpu_halt && sleep_exec |=> cpu_halt)
    else $error("sleep instruction did not halt processor");
  a_sleep_periph: assert property (cpu_halt && !periph_halt |-> clk_en.periph_en)
    else $error("peripherals stopped in sleep");
  a_sleep_wake: assert property (cpu_halt && !periph_halt && wake_irq |=> !cpu_halt)
    else $error("sleep not left on wake");
  a_settle_wait: assert property (osc_stop && !periph_reset && wake_irq
    |=> (!osc_stop && cpu_halt) [*4])
    else $error("standby exit skipped settling");
  a_stop_write: assert property (!stop_wr_reg |=> $stable(module_stop))
    else $error("module stop changed without write");
endmodule
bind ccg_top ccg_top_checker #(.MSTOP_W(MSTOP_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
  .clk_en(clk_en), .cpu_halt(cpu_halt), .periph_halt(periph_halt),
  .periph_reset(periph_reset), .osc_stop(osc_stop), .pll_select(pll_select),
  .module_stop(module_stop)
);
`default_nettype wire

// ===== tb_ccg_top.sv
// self-checking bench for ccg_top, registers reached over ahb-lite
// assumes ccg_pkg compiled first and the checker bound onto the dut
`timescale 1ns/1ps
`default_nettype none
module tb_ccg_top;
  import ccg_pkg::*;
  localparam int BASE = 8;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic sleep_exec = 0, wake_irq = 0, bus_cycle_done = 1, dtc_req = 0;
  logic flash_enable_bit = 0, hw_standby_n = 1, subclock_pin, run = 1, glitch = 0;
  logic cpu_halt, periph_halt, periph_reset, osc_stop, pll_select, subclock_out;
  logic [15:0] module_stop;
  ccg_en_t clk_en;
  int fail_count = 0, n_tests = 0, cycles = 0, c, n;
  ccg_top #(.SETTLE_BASE(BASE), .MSTOP_W(16)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .bus_cycle_done(bus_cycle_done), .dtc_req(dtc_req),
    .flash_enable_bit(flash_enable_bit), .hw_standby_n(hw_standby_n),
    .subclock_pin(subclock_pin), .clk_en(clk_en), .cpu_halt(cpu_halt),
    .periph_halt(periph_halt), .periph_reset(periph_reset), .osc_stop(osc_stop),
    .pll_select(pll_select), .module_stop(module_stop), .subclock_out(subclock_out)
  );
  ccg_subclk_src #(.HALF(128)) src (.hclk(hclk), .run(run), .glitch(glitch), .pin(subclock_pin));
  // clock and a cycle ceiling so a hang still reaches the report
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one single transfer; entered right after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // one-cycle pulse on the wake input (wake=1) or the sleep input (wake=0)
  task automatic pulse(input logic wake);
    if (wake) begin
      wake_irq <= 1'b1;
    end else begin
      sleep_exec <= 1'b1;
    end
    @(posedge hclk);
    sleep_exec <= 1'b0;
    wake_irq <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic count(input int len, input int b, output int k);
    k = 0;
    // sampled mid-cycle, where the combinational enables have settled
    repeat (len) begin
      @(negedge hclk);
      k += clk_en[b];
    end
    @(posedge hclk);
  endtask
  // wait for a pin edge of the source, then d more cycles
  task automatic edge_wait(input int d);
    logic p;
    p = subclock_pin;
    while (subclock_pin === p) @(posedge hclk);
    repeat (d) @(posedge hclk);
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    rd(32'hc, 32'h440);
    rd(32'h10, 32'h0);
    for (int s = 0; s < 6; s++) begin
      wr(32'h0, s);
      repeat (40) @(posedge hclk);
      count(64, 2, c);
      chk(c, 64 >> s);
      rd(32'hc, 32'h440 | s);
    end
    wr(32'h0, 32'h6);
    rd(32'h0, 32'h5);
    bus_cycle_done <= 1'b0;
    wr(32'h0, 32'h1);
    repeat (70) @(posedge hclk);
    rd(32'hc, 32'h445);
    bus_cycle_done <= 1'b1;
    repeat (40) @(posedge hclk);
    rd(32'hc, 32'h441);
    wr(32'h0, 32'h5);
    repeat (40) @(posedge hclk);
    dtc_req <= 1'b1;
    count(64, 1, c);
    chk(c, 2);
    wr(32'h0, 32'hd);
    count(32, 1, c);
    chk(c, 32);
    dtc_req <= 1'b0;
    flash_enable_bit <= 1'b1;
    wr(32'h8, 32'h5a5a);
    rd(32'h8, 32'h0);
    chk(hresp, 1'b0);
    flash_enable_bit <= 1'b0;
    wr(32'h8, 32'h5a5a);
    rd(32'h8, 32'h5a5a);
    chk(module_stop, 32'h5a5a);
    wr(32'h0, 32'h0);
    pulse(1'b0);
    chk({cpu_halt, periph_halt, clk_en.periph_en}, 3'b101);
    pulse(1'b1);
    chk(cpu_halt, 1'b0);
    // settling wait per timer code, counted from entry into settling
    for (int t = 0; t < 6; t++) begin
      wr(32'h0, 32'h80 | (t << 4));
      pulse(1'b0);
      chk({osc_stop, periph_halt, clk_en}, 5'b11000);
      pulse(1'b1);
      chk(osc_stop, 1'b0);
      // one settling cycle is behind us; count the rest at falling edges
      n = 1;
      @(negedge hclk);
      while (cpu_halt === 1'b1 && n < 3000) begin
        n++;
        @(negedge hclk);
      end
      @(posedge hclk);
      chk(n, BASE << t);
      rd(32'h0, 32'h80 | (t << 4));
    end
    hw_standby_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({periph_reset, osc_stop}, 2'b11);
    hw_standby_n <= 1'b1;
    repeat (30) @(posedge hclk);
    chk({cpu_halt, pll_select}, 2'b01);
    wr(32'h4, 32'h30);
    edge_wait(30);
    chk(subclock_out, subclock_pin);
    // a spike shorter than three samples must not reach the output
    glitch <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(subclock_out, !subclock_pin);
    glitch <= 1'b0;
    repeat (20) @(posedge hclk);
    chk(subclock_out, subclock_pin);
    wr(32'h4, 32'h10);
    edge_wait(30);
    chk(subclock_out, !subclock_pin);
    repeat (80) @(posedge hclk);
    chk(subclock_out, subclock_pin);
    wr(32'h4, 32'h0);
    repeat (10) @(posedge hclk);
    chk(subclock_out, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
